// ==== design/asf_serial_port.v ====
// single-channel async serial port: holding register, frame format, prescaler, tx and rx shifters
// assumes a 25 MHz clk, an axi4-lite master, and an asynchronous rx pin
`timescale 1ns/10ps
`default_nettype none
`include "asf_regs.vh"
module asf_serial_port #(
  parameter OVS = 16  // clocks of the prescaled tick per bit
) (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // axi4-lite write address and data
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial lines
  output reg         txLine,
  input  wire        rxLine
);

  localparam ST_IDLE = 3'h0;
  localparam ST_STRT = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR  = 3'h3;
  localparam ST_STOP = 3'h4;

  // registers
  reg  [7:0]  transmitHoldingReg_ff;
  reg  [7:0]  frameModeReg_ff;
  reg         txEnable_ff;
  reg         holdingEmptyFlag_ff;
  reg  [7:0]  rxData_ff;
  reg         rxFull_ff;
  reg         parErr_ff;
  reg         frmErr_ff;
  reg         mpBit_ff;
  // bus capture
  reg  [3:0]  awAddr_ff;
  reg         awHave_ff;
  reg  [31:0] wData_ff;
  reg  [3:0]  wStrb_ff;
  reg         wHave_ff;
  // prescaler and bit tick
  reg  [5:0]  preCnt_ff;
  reg  [3:0]  bitDiv_ff;
  // transmitter
  reg  [2:0]  txState_ff;
  reg  [7:0]  transmitShiftReg_ff;
  reg  [2:0]  txCnt_ff;
  reg         txPar_ff;
  reg         txStop2_ff;
  // receiver
  reg  [1:0]  rxSync_ff;
  reg  [2:0]  rxState_ff;
  reg  [7:0]  receiveShiftReg_ff;
  reg  [2:0]  rxCnt_ff;
  reg  [3:0]  rxPh_ff;
  reg         rxPar_ff;

  wire char7   = frameModeReg_ff[`ASF_BIT_CHAR7];
  wire mproc   = frameModeReg_ff[`ASF_BIT_MPROC];
  wire parOn   = frameModeReg_ff[`ASF_BIT_PAREN] & ~mproc;
  wire parOdd  = frameModeReg_ff[`ASF_BIT_PARODD] & parOn;
  wire [1:0] prescaleSel = {frameModeReg_ff[`ASF_BIT_PSHI], frameModeReg_ff[`ASF_BIT_PSLO]};
  wire rxIn    = rxSync_ff[1];

  // prescaler terminal count for a selection, used for the tick below
  function [5:0] preTop;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    preTop = 6'h00;
        2'h1:    preTop = 6'h03;
        2'h2:    preTop = 6'h0F;
        default: preTop = 6'h3F;
      endcase
    end
  endfunction

  // divider end points cut to the counter width on purpose
  localparam [31:0] BIT_TOP_W = OVS - 1;
  localparam [31:0] MID_TOP_W = OVS / 2 - 1;
  localparam [3:0]  BIT_TOP   = BIT_TOP_W[3:0];
  localparam [3:0]  MID_TOP   = MID_TOP_W[3:0];

  wire preTick = (preCnt_ff >= preTop(prescaleSel));
  wire bitTick = preTick & (bitDiv_ff == BIT_TOP);
  wire midTick = preTick & (rxPh_ff == MID_TOP);

  wire wrFire  = awHave_ff & wHave_ff & ~s_axi_bvalid;
  wire wrHold  = wrFire & (awAddr_ff == `ASF_OFF_HOLD) & wStrb_ff[0];
  wire wrMode  = wrFire & (awAddr_ff == `ASF_OFF_MODE) & wStrb_ff[0];
  wire wrCtrl  = wrFire & (awAddr_ff == `ASF_OFF_CTRL) & wStrb_ff[0];
  wire wrStat  = wrFire & (awAddr_ff == `ASF_OFF_STAT) & wStrb_ff[0];
  // a load may also end the last stop bit, so back-to-back frames leave no idle bit
  wire txLoad  = txEnable_ff & ~holdingEmptyFlag_ff & bitTick &
                 ((txState_ff == ST_IDLE) | ((txState_ff == ST_STOP) & ~txStop2_ff));

  // prescaler and per-bit divider share one free-running chain
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preCnt_ff <= 6'h00;
      bitDiv_ff <= 4'h0;
    end else begin
      preCnt_ff <= preTick ? 6'h00 : preCnt_ff + 6'h01;
      if (preTick)
        bitDiv_ff <= (bitDiv_ff == BIT_TOP) ? 4'h0 : bitDiv_ff + 4'h1;
    end
  end

  // axi write channel: address and data taken in either order, then one response
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      awHave_ff     <= 1'b0;
      wHave_ff      <= 1'b0;
      awAddr_ff     <= 4'h0;
      wData_ff      <= 32'h0;
      wStrb_ff      <= 4'h0;
    end else begin
      s_axi_awready <= ~awHave_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wHave_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_ff[1:0] == 2'h0) ? 2'h0 : 2'h2;  // misaligned gets slverr
        awHave_ff    <= 1'b0;
        wHave_ff     <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers; hardware sets of status win over software clears
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmitHoldingReg_ff <= `ASF_RST_HOLD;
      frameModeReg_ff       <= `ASF_RST_MODE;
      txEnable_ff           <= 1'b0;
      holdingEmptyFlag_ff   <= 1'b1;
    end else begin
      if (wrHold)
        transmitHoldingReg_ff <= wData_ff[7:0];
      if (wrMode)
        frameModeReg_ff <= wData_ff[7:0] & `ASF_MODE_WMASK;
      if (wrCtrl)
        txEnable_ff <= wData_ff[`ASF_BIT_TXEN];
      // writing zero to the empty flag arms a send; disabled transmitter pins it at one
      if (!txEnable_ff || txLoad)
        holdingEmptyFlag_ff <= 1'b1;
      else if (wrStat && !wData_ff[`ASF_BIT_EMPTY])
        holdingEmptyFlag_ff <= 1'b0;
    end
  end

  // transmitter: start, data lsb first, optional parity, one or two stops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txState_ff          <= ST_IDLE;
      transmitShiftReg_ff <= 8'hFF;
      txCnt_ff            <= 3'h0;
      txPar_ff            <= 1'b0;
      txStop2_ff          <= 1'b0;
      txLine              <= 1'b1;
    end else if (txLoad) begin
      transmitShiftReg_ff <= transmitHoldingReg_ff;
      txPar_ff   <= parOdd ^ (^(transmitHoldingReg_ff & {~char7, 7'h7F}));
      txStop2_ff <= frameModeReg_ff[`ASF_BIT_STOP2];
      txCnt_ff   <= char7 ? 3'h6 : 3'h7;
      txLine     <= 1'b0;
      txState_ff <= ST_STRT;
    end else if (bitTick) begin
      case (txState_ff)
        ST_IDLE: begin
          txLine <= 1'b1;
        end
        ST_STRT: begin
          txLine              <= transmitShiftReg_ff[0];
          transmitShiftReg_ff <= {1'b1, transmitShiftReg_ff[7:1]};
          txState_ff          <= ST_DATA;
        end
        ST_DATA: begin
          if (txCnt_ff == 3'h0) begin
            txLine     <= parOn ? txPar_ff : 1'b1;
            txState_ff <= parOn ? ST_PAR : ST_STOP;
          end else begin
            txLine              <= transmitShiftReg_ff[0];
            transmitShiftReg_ff <= {1'b1, transmitShiftReg_ff[7:1]};
            txCnt_ff            <= txCnt_ff - 3'h1;
          end
        end
        ST_PAR: begin
          txLine     <= 1'b1;
          txState_ff <= ST_STOP;
        end
        ST_STOP: begin
          txLine <= 1'b1;
          if (txStop2_ff)
            txStop2_ff <= 1'b0;
          else
            txState_ff <= ST_IDLE;
        end
        default: txState_ff <= ST_IDLE;
      endcase
    end
  end

  // rx pin synchroniser, the first stage feeds only the second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      rxSync_ff <= 2'h3;
    else
      rxSync_ff <= {rxSync_ff[0], rxLine};
  end

  // receiver: samples mid-bit, checks first stop only, so a low second stop is a new start
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState_ff         <= ST_IDLE;
      receiveShiftReg_ff <= 8'h00;
      rxCnt_ff           <= 3'h0;
      rxPh_ff            <= 4'h0;
      rxPar_ff           <= 1'b0;
      rxData_ff          <= 8'h00;
      rxFull_ff          <= 1'b0;
      parErr_ff          <= 1'b0;
      frmErr_ff          <= 1'b0;
      mpBit_ff           <= 1'b0;
    end else begin
      if (wrStat) begin
        if (!wData_ff[`ASF_BIT_RXFULL]) rxFull_ff <= 1'b0;
        if (!wData_ff[`ASF_BIT_PARERR]) parErr_ff <= 1'b0;
        if (!wData_ff[`ASF_BIT_FRMERR]) frmErr_ff <= 1'b0;
      end
      if (preTick)
        rxPh_ff <= (rxState_ff == ST_IDLE) ? 4'h0 :
                   (rxPh_ff == BIT_TOP) ? 4'h0 : rxPh_ff + 4'h1;
      case (rxState_ff)
        ST_IDLE: if (!rxIn) rxState_ff <= ST_STRT;
        ST_STRT: if (midTick) begin
          rxState_ff <= rxIn ? ST_IDLE : ST_DATA;
          rxCnt_ff   <= char7 ? 3'h6 : 3'h7;
          rxPar_ff   <= parOdd;
        end
        ST_DATA: if (midTick) begin
          receiveShiftReg_ff <= char7 ? {1'b0, rxIn, receiveShiftReg_ff[6:1]}
                                      : {rxIn, receiveShiftReg_ff[7:1]};
          rxPar_ff <= rxPar_ff ^ rxIn;
          if (rxCnt_ff == 3'h0)
            rxState_ff <= (parOn | mproc) ? ST_PAR : ST_STOP;
          else
            rxCnt_ff <= rxCnt_ff - 3'h1;
        end
        ST_PAR: if (midTick) begin
          rxPar_ff   <= rxPar_ff ^ rxIn;
          mpBit_ff   <= mproc ? rxIn : mpBit_ff;
          rxState_ff <= ST_STOP;
        end
        ST_STOP: if (midTick) begin
          rxState_ff <= ST_IDLE;
          rxData_ff  <= receiveShiftReg_ff;
          rxFull_ff  <= 1'b1;
          if (parOn && rxPar_ff) parErr_ff <= 1'b1;
          if (!rxIn) frmErr_ff <= 1'b1;
        end
        default: rxState_ff <= ST_IDLE;
      endcase
    end
  end

  // axi read channel, one cycle after the address is taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[3:0])
          `ASF_OFF_HOLD: s_axi_rdata <= {24'h0, transmitHoldingReg_ff};
          `ASF_OFF_MODE: s_axi_rdata <= {24'h0, frameModeReg_ff};
          `ASF_OFF_CTRL: s_axi_rdata <= {31'h0, txEnable_ff};
          `ASF_OFF_STAT: s_axi_rdata <= {16'h0, rxData_ff, 3'h0, mpBit_ff, rxFull_ff,
                                         frmErr_ff, parErr_ff, holdingEmptyFlag_ff};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== design/asf_regs.vh ====
// register map, field positions and reset values of the async frame block
// assumes a 32-bit axi4-lite slave, one register per aligned word
`ifndef ASF_REGS_VH
`define ASF_REGS_VH
`define ASF_OFF_HOLD      4'h0
`define ASF_OFF_MODE      4'h4
`define ASF_OFF_CTRL      4'h8
`define ASF_OFF_STAT      4'hC
`define ASF_RST_HOLD      8'hFF
`define ASF_RST_MODE      8'h00
`define ASF_MODE_WMASK    8'h7F
`define ASF_BIT_CHAR7     6
`define ASF_BIT_PAREN     5
`define ASF_BIT_PARODD    4
`define ASF_BIT_STOP2     3
`define ASF_BIT_MPROC     2
`define ASF_BIT_PSHI      1
`define ASF_BIT_PSLO      0
`define ASF_BIT_TXEN      0
`define ASF_BIT_EMPTY     0
`define ASF_BIT_PARERR    1
`define ASF_BIT_FRMERR    2
`define ASF_BIT_RXFULL    3
`define ASF_BIT_MPBIT     4
`define ASF_RST_DIV       8'h00
`endif

// ==== tb/asf_serial_port_sva.sv ====
// bus handshake and tx line timing checks for the async serial port
// assumes it is bound onto asf_serial_port; only the top ports are seen
`timescale 1ns/10ps
`default_nettype none
module asf_serial_port_sva #(
  parameter OVS = 16
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // serial out
  input wire logic        txLine
);
  logic [3:0] rdAddr_ff;
  // remember the read offset so the answer can be judged
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdAddr_ff <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready) rdAddr_ff <= s_axi_araddr[3:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write response");
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stands: assert property (p_b_stands) else $error("write response dropped");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read data");
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stands: assert property (p_r_stands) else $error("read data not held");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
  property p_mode_top;
    s_axi_rvalid && rdAddr_ff == 4'h4 |-> s_axi_rdata[31:7] == 25'h0;
  endproperty
  a_mode_top: assert property (p_mode_top) else $error("mode top bit set");
  property p_hold_width;
    s_axi_rvalid && rdAddr_ff == 4'h0 |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0;
  endproperty
  a_hold_width: assert property (p_hold_width) else $error("holding read bad");
  property p_idle_high;
    $rose(arst_n) |-> txLine;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("tx not idle high");
  property p_start_len;
    $fell(txLine) |-> !txLine [*4];
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
  property p_bit_min;
    $changed(txLine) |=> $stable(txLine) [*3];
  endproperty
  a_bit_min: assert property (p_bit_min) else $error("bit shorter than tick");
  c_start: cover property ($fell(txLine));
  c_mode_rd: cover property (s_axi_rvalid && rdAddr_ff == 4'h4);
  c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind asf_serial_port asf_serial_port_sva #(.OVS(OVS)) u_sva (.*);
`default_nettype wire

// ==== tb/asf_far_end.sv ====
// far-end receiver model: decodes tx frames and times start edges
// assumes the bench sets bit and frame length before each transfer
`timescale 1ns/10ps
`default_nettype none
module asf_far_end (
  // clock and bench settings
  input  wire logic        clk,
  input  wire logic [15:0] bitClks,
  input  wire logic [3:0]  frameLen,
  // serial lines
  input  wire logic        txLine,
  output var  logic        rxLine,
  // decoded results
  output var  logic [11:0] frameBits,
  output var  logic [15:0] frameGap,
  output var  logic [7:0]  frameCnt
);
  int          nClk = 0;
  int          tStart = 0;
  logic [11:0] bits;
  // free clock count for start edge spacing
  always @(posedge clk) nClk <= nClk + 1;
  // far end never talks back here, so its line rests high
  initial begin
    rxLine = 1'b1;
    frameCnt = 8'h00;
    frameGap = 16'h0000;
    frameBits = 12'hFFF;
    forever begin
      @(negedge txLine);
      frameGap = 16'(nClk - tStart);
      tStart = nClk;
      bits = 12'hFFF;
      repeat (bitClks / 2) @(posedge clk);
      // mid-bit sampling, lsb right after the start bit
      for (int i = 0; i < frameLen; i++) begin
        bits[i] = txLine;
        if (i < frameLen - 1) repeat (bitClks) @(posedge clk);
      end
      frameBits = bits;
      frameCnt = frameCnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== tb/asf_serial_port_test.sv ====
// self-checking bench: register access, frame formats, gapless sends
// assumes the far-end model decodes the tx line
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module asf_serial_port_test;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rdVal;
  logic        txLine, rxLine;
  logic [15:0] bitClks = 16'h4, frameGap;
  logic [3:0]  frameLen = 4'hA;
  logic [11:0] frameBits;
  logic [7:0]  frameCnt;
  logic [7:0]  b1 = 8'hB4;
  logic [7:0]  modes [8] = '{8'h00, 8'h41, 8'h20, 8'h30, 8'h10, 8'h0A, 8'h34, 8'h63};
  int          n_errors = 0, samples_checked = 0;
  asf_serial_port #(.OVS(4)) u_dut (.*);
  asf_far_end u_far (.*);
  always #20 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic stall();
    n_errors++;
    report_and_stop();
  endtask
  // one write; address and data released as each is taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 100) stall();
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 100) stall();
  endtask
  task automatic t_regs();
    rd(32'h0, rdVal, rr);
    `CHK("hold reset", 32'hFF, rdVal)
    rd(32'h4, rdVal, rr);
    `CHK("mode reset", 32'h0, rdVal)
    wr(32'h4, 32'hFF);
    rd(32'h4, rdVal, rr);
    `CHK("mode top bit", 32'h7F, rdVal)
    wr(32'h0, 32'h5A);
    rd(32'h0, rdVal, rr);
    `CHK("hold rw", 32'h5A, rdVal)
    rd(32'h2, rdVal, rr);
    `CHK("unmapped resp", 2'h2, rr)
  endtask
  // enabled but never armed: nothing may leave
  task automatic t_hold();
    logic [7:0] c0;
    wr(32'h8, 32'h1);
    c0 = frameCnt;
    wr(32'h0, 32'h11);
    repeat (64) @(posedge clk);
    `CHK("no send while empty", c0, frameCnt)
    `CHK("idle line", 1'b1, txLine)
  endtask
  // two bytes back to back; the second frame and the start spacing are judged
  task automatic t_frame(input logic [7:0] m);
    logic [11:0] e;
    logic [7:0]  c0;
    int          nd, k;
    nd = m[6] ? 7 : 8;
    e = 12'hFFF;
    e[0] = 1'b0;
    for (k = 0; k < nd; k++) e[1 + k] = b1[k];
    if (m[5] && !m[2]) e[1 + nd] = ^(b1 & (nd == 8 ? 8'hFF : 8'h7F)) ^ m[4];
    bitClks <= 16'(4 << (2 * m[1:0]));
    frameLen <= 4'(2 + nd + (m[5] && !m[2]) + m[3]);
    wr(32'h4, {24'h0, m});
    wr(32'h0, 32'h3C);
    c0 = frameCnt;
    wr(32'hC, 32'h0);
    for (k = 0; k < 400; k++) begin
      rd(32'hC, rdVal, rr);
      if (rdVal[0]) break;
    end
    if (k == 400) stall();
    wr(32'h0, {24'h0, b1});
    wr(32'hC, 32'h0);
    for (k = 0; k < 8000 && frameCnt != c0 + 8'h02; k++) @(posedge clk);
    if (k == 8000) stall();
    `CHK("frame bits", e, frameBits)
    `CHK("start spacing", 16'(frameLen * bitClks), frameGap)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_hold();
    foreach (modes[j]) t_frame(modes[j]);
    report_and_stop();
  end
endmodule
`default_nettype wire
